// >>> pkg/sldb_pkg.sv
package sldb_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] FLASH_CTRL_OFS = 8'h00;
  localparam logic [7:0] DISP_CFG_OFS = 8'h04;
  localparam logic [7:0] SUPPLY_CFG_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;
  localparam logic [7:0] WAVE_BASE_OFS = 8'h10;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int FL_EN_BIT = 0;
  localparam int FL_MODE_BIT = 1;
  localparam int FL_RATE_LSB = 2;
  localparam int FL_ALT_BIT = 5;
  localparam int FL_CLR_BIT = 6;
  localparam int DC_DUTY_LSB = 0;
  localparam int DC_PANEL_BIT = 3;
  localparam int SC_SRC_LSB = 0;
  localparam int SC_DIVREF_BIT = 2;
  localparam int SC_SKIP_BIT = 3;
  localparam int SC_PUMPSEL_BIT = 4;
  localparam int SC_PUMPEN_BIT = 5;
  localparam int ST_BLINK_BIT = 0;
  localparam int ST_MODE_LSB = 1;
  localparam int ST_HOLD_BIT = 3;
  localparam int ST_SW_LSB = 4;
  localparam int ST_BUF_BIT = 7;
  localparam int ST_PHASE_LSB = 8;
  // ----------------------------------------
  // Reset values and codes
  // ----------------------------------------
  localparam logic [1:0] SUPPLY_SRC_RST = 2'h1;
  localparam logic [1:0] SRC_SW1 = 2'h0;
  localparam logic [1:0] SRC_SW2 = 2'h1;
  localparam logic [1:0] SRC_SW3 = 2'h2;
  localparam logic [2:0] DUTY_ALT_MAX = 3'h3;
  localparam logic [2:0] ALT_PHASE_OFS = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int SYS_CLK_HZ = 25_000_000;
  localparam int BASE_CLK_HZ = 32_768;
  localparam int BASE_DIV = SYS_CLK_HZ / BASE_CLK_HZ;
  localparam logic [9:0] BASE_DIV_LAST = 10'(BASE_DIV - 1);
  localparam logic [4:0] HOLD_TICKS = 5'h10;
  localparam int BLINK_BASE = 4096;
  localparam int BLINK_CNT_W = 20;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    SLDB_DISP_NORMAL = 2'h0,
    SLDB_DISP_CLEAR = 2'h1,
    SLDB_DISP_ALT = 2'h2
  } sldb_disp_t;
  typedef enum logic [2:0] {
    SLDB_RD_IDLE = 3'h1,
    SLDB_RD_FETCH = 3'h2,
    SLDB_RD_RESP = 3'h4
  } sldb_rd_t;
endpackage : sldb_pkg

// >>> pkg/sldb_link_if.sv
`timescale 1ns/1ps
interface sldb_link_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_err;
  logic tick;
  logic flash_en;
  logic [2:0] rate;
  logic blink_period;
  modport bus(output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
              input wr_err, rd_data, rd_err);
  modport flash(input tick, flash_en, rate, output blink_period);
endinterface : sldb_link_if

// >>> rtl/sldb_flash.sv
`timescale 1ns/1ps
module sldb_flash #(
  parameter int BLINK_BASE = sldb_pkg::BLINK_BASE
) (
  input wire logic aclk,
  input wire logic aresetn,
  sldb_link_if.flash f
);
  import sldb_pkg::*;
  logic [BLINK_CNT_W-1:0] cnt_reg, cnt_next, last;
  logic period_reg, period_next;

  // Terminal count scales by powers of two with the rate
  assign last = (BLINK_CNT_W'(BLINK_BASE) << f.rate) - 1'b1;
  assign f.blink_period = period_reg;

  always_comb begin
    cnt_next = cnt_reg;
    period_next = period_reg;
    if (!f.flash_en) begin
      cnt_next = '0;
      period_next = 1'b0;
    end else if (f.tick) begin
      if (cnt_reg >= last) begin
        cnt_next = '0;
        period_next = !period_reg;
      end else begin
        cnt_next = cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= '0;
      period_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      period_reg <= period_next;
    end
  end
endmodule : sldb_flash

// >>> rtl/sldb_axil_slave.sv
`timescale 1ns/1ps
module sldb_axil_slave (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [sldb_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [sldb_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [sldb_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [sldb_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  sldb_link_if.bus l
);
  import sldb_pkg::*;
  logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
  logic awready_reg, awready_next, wready_reg, wready_next;
  logic bvalid_reg, bvalid_next, do_write;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [ADDR_W-1:0] awaddr_reg, awaddr_next, araddr_reg, araddr_next;
  logic [DATA_W-1:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic arready_reg, arready_next, rvalid_reg, rvalid_next;
  sldb_rd_t rd_state_reg, rd_state_next;

  assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;
  assign l.wr_en = do_write;
  assign l.wr_addr = awaddr_reg;
  assign l.wr_data = wdata_reg;
  assign l.wr_strb = wstrb_reg;
  assign l.rd_addr = araddr_reg;
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // ----------------------------------------
  // Write channels, taken in either order
  // ----------------------------------------
  always_comb begin
    aw_full_next = aw_full_reg;
    w_full_next = w_full_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    if (s_axi_awvalid && awready_reg) begin
      aw_full_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_full_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (do_write) begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = l.wr_err ? RESP_SLVERR : RESP_OKAY;
    end
    // One write in flight: no new address or data until the response is taken
    awready_next = !aw_full_next && !bvalid_next;
    wready_next = !w_full_next && !bvalid_next;
  end

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  always_comb begin
    rd_state_next = rd_state_reg;
    araddr_next = araddr_reg;
    arready_next = arready_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    case (rd_state_reg)
      SLDB_RD_IDLE: begin
        if (s_axi_arvalid && arready_reg) begin
          araddr_next = s_axi_araddr;
          arready_next = 1'b0;
          rd_state_next = SLDB_RD_FETCH;
        end
      end
      SLDB_RD_FETCH: begin
        rdata_next = l.rd_data;
        rresp_next = l.rd_err ? RESP_SLVERR : RESP_OKAY;
        rvalid_next = 1'b1;
        rd_state_next = SLDB_RD_RESP;
      end
      SLDB_RD_RESP: begin
        if (s_axi_rready) begin
          rvalid_next = 1'b0;
          arready_next = 1'b1;
          rd_state_next = SLDB_RD_IDLE;
        end
      end
      default: begin
        rvalid_next = 1'b0;
        arready_next = 1'b1;
        rd_state_next = SLDB_RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rd_state_reg <= SLDB_RD_IDLE;
      araddr_reg <= '0;
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rd_state_reg <= rd_state_next;
      araddr_reg <= araddr_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end
endmodule : sldb_axil_slave

// >>> rtl/sldb_top.sv
// The register addresses and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
module sldb_top #(
  parameter int NUM_PINS = 16,
  parameter int BLINK_BASE = sldb_pkg::BLINK_BASE
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [sldb_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [sldb_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [sldb_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [sldb_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [NUM_PINS-1:0] seg_drive,
  output logic seg_drive_en,
  output logic supply_switch_one,
  output logic supply_switch_two,
  output logic supply_switch_three,
  output logic ref_buffer_en,
  output logic divider_en,
  output logic pump_run,
  output logic resistor_bias_run
);
  import sldb_pkg::*;
  localparam logic [7:0] WAVE_END = 8'(WAVE_BASE_OFS + NUM_PINS);

  sldb_link_if l ();

  // ----------------------------------------
  // Software-visible state
  // ----------------------------------------
  logic [6:0] flash_reg, flash_next;
  logic [3:0] disp_reg, disp_next;
  logic [5:0] supply_reg, supply_next;
  logic [7:0] wave_reg [NUM_PINS];
  logic [7:0] wave_next [NUM_PINS];
  logic pump_start;
  logic wave_wr_hit, wave_rd_hit;
  logic [2:0] duty;
  logic many_bp;

  assign duty = disp_reg[DC_DUTY_LSB +: 3];
  assign many_bp = duty > DUTY_ALT_MAX;
  assign wave_wr_hit = l.wr_addr >= WAVE_BASE_OFS && l.wr_addr < WAVE_END
                       && l.wr_addr[1:0] == 2'h0;
  assign wave_rd_hit = l.rd_addr >= WAVE_BASE_OFS && l.rd_addr < WAVE_END
                       && l.rd_addr[1:0] == 2'h0;
  assign l.wr_err = !(l.wr_addr == FLASH_CTRL_OFS || l.wr_addr == DISP_CFG_OFS
                      || l.wr_addr == SUPPLY_CFG_OFS || l.wr_addr == STATUS_OFS
                      || wave_wr_hit);

  always_comb begin
    flash_next = flash_reg;
    disp_next = disp_reg;
    supply_next = supply_reg;
    pump_start = 1'b0;
    for (int i = 0; i < NUM_PINS; i++) begin
      wave_next[i] = wave_reg[i];
    end
    if (l.wr_en) begin
      if (l.wr_addr == FLASH_CTRL_OFS && l.wr_strb[0]) begin
        flash_next = l.wr_data[6:0];
      end
      if (l.wr_addr == DISP_CFG_OFS && l.wr_strb[0]) begin
        disp_next = l.wr_data[3:0];
      end
      if (l.wr_addr == SUPPLY_CFG_OFS && l.wr_strb[0]) begin
        supply_next = l.wr_data[5:0];
        // Only a 0 to 1 change of the pump enable restarts the hold
        pump_start = l.wr_data[SC_PUMPEN_BIT] && !supply_reg[SC_PUMPEN_BIT];
      end
      for (int i = 0; i < NUM_PINS; i++) begin
        if (wave_wr_hit && l.wr_addr == 8'(WAVE_BASE_OFS + 4 * (i / 4))
            && l.wr_strb[i % 4]) begin
          wave_next[i] = l.wr_data[8 * (i % 4) +: 8];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flash_reg <= '0;
      disp_reg <= '0;
      supply_reg <= {4'h0, SUPPLY_SRC_RST};
      for (int i = 0; i < NUM_PINS; i++) begin
        wave_reg[i] <= 8'h00;
      end
    end else begin
      flash_reg <= flash_next;
      disp_reg <= disp_next;
      supply_reg <= supply_next;
      for (int i = 0; i < NUM_PINS; i++) begin
        wave_reg[i] <= wave_next[i];
      end
    end
  end

  // ----------------------------------------
  // Base tick, phase sequencer, pump hold
  // ----------------------------------------
  logic [9:0] div_reg, div_next;
  logic tick_reg, tick_next;
  logic [2:0] phase_reg, phase_next;
  logic [4:0] hold_reg, hold_next;

  always_comb begin
    div_next = div_reg + 1'b1;
    tick_next = 1'b0;
    if (div_reg == BASE_DIV_LAST) begin
      div_next = '0;
      tick_next = 1'b1;
    end
    phase_next = phase_reg;
    if (tick_reg) begin
      phase_next = (phase_reg >= duty) ? 3'h0 : phase_reg + 1'b1;
    end
    hold_next = hold_reg;
    if (pump_start) begin
      hold_next = HOLD_TICKS;
    end else if (tick_reg && hold_reg != 5'h00) begin
      hold_next = hold_reg - 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_reg <= '0;
      tick_reg <= 1'b0;
      phase_reg <= 3'h0;
      hold_reg <= 5'h00;
    end else begin
      div_reg <= div_next;
      tick_reg <= tick_next;
      phase_reg <= phase_next;
      hold_reg <= hold_next;
    end
  end

  // ----------------------------------------
  // Blink divider
  // ----------------------------------------
  assign l.tick = tick_reg;
  assign l.flash_en = flash_reg[FL_EN_BIT];
  assign l.rate = flash_reg[FL_RATE_LSB +: 3];

  sldb_flash #(
    .BLINK_BASE(BLINK_BASE)
  ) u_flash (
    .aclk(aclk),
    .aresetn(aresetn),
    .f(l.flash)
  );

  // ----------------------------------------
  // Display mode selection
  // ----------------------------------------
  sldb_disp_t normal_pick, blink_pick, shown;

  always_comb begin
    if (flash_reg[FL_CLR_BIT]) begin
      normal_pick = SLDB_DISP_CLEAR;
    end else if (flash_reg[FL_ALT_BIT]) begin
      normal_pick = many_bp ? SLDB_DISP_CLEAR : SLDB_DISP_ALT;
    end else begin
      normal_pick = SLDB_DISP_NORMAL;
    end
    if (flash_reg[FL_MODE_BIT] && !many_bp) begin
      blink_pick = SLDB_DISP_ALT;
    end else begin
      blink_pick = SLDB_DISP_CLEAR;
    end
    shown = (l.flash_en && l.blink_period) ? blink_pick : normal_pick;
  end

  // ----------------------------------------
  // Pin and supply outputs
  // ----------------------------------------
  logic [NUM_PINS-1:0] seg_next, seg_reg;
  logic [2:0] eff_phase;
  logic seg_en_reg, seg_en_next;
  logic [2:0] sw_reg, sw_next;
  logic buf_reg, buf_next, div_en_reg, div_en_next;
  logic pump_reg, pump_next, res_reg, res_next;

  // Upper phases hold the second image
  assign eff_phase = (shown == SLDB_DISP_ALT) ? phase_reg + ALT_PHASE_OFS : phase_reg;

  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : g_pin
      // Cleared ignores the stored data entirely
      assign seg_next[g] = (shown != SLDB_DISP_CLEAR) && wave_reg[g][eff_phase];
    end
  endgenerate

  always_comb begin
    // Pump hold wins over the panel enable
    seg_en_next = disp_reg[DC_PANEL_BIT] && hold_reg == 5'h00;
    case (supply_reg[SC_SRC_LSB +: 2])
      SRC_SW1: sw_next = 3'b001;
      SRC_SW2: sw_next = 3'b010;
      SRC_SW3: sw_next = 3'b100;
      default: sw_next = 3'b000;
    endcase
    buf_next = !supply_reg[SC_SKIP_BIT] && sw_next[2];
    div_en_next = !supply_reg[SC_DIVREF_BIT];
    pump_next = supply_reg[SC_PUMPSEL_BIT];
    res_next = !supply_reg[SC_PUMPSEL_BIT];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seg_reg <= '0;
      seg_en_reg <= 1'b0;
      sw_reg <= 3'b000;
      buf_reg <= 1'b0;
      div_en_reg <= 1'b0;
      pump_reg <= 1'b0;
      res_reg <= 1'b0;
    end else begin
      seg_reg <= seg_next;
      seg_en_reg <= seg_en_next;
      sw_reg <= sw_next;
      buf_reg <= buf_next;
      div_en_reg <= div_en_next;
      pump_reg <= pump_next;
      res_reg <= res_next;
    end
  end

  assign seg_drive = seg_reg;
  assign seg_drive_en = seg_en_reg;
  assign supply_switch_one = sw_reg[0];
  assign supply_switch_two = sw_reg[1];
  assign supply_switch_three = sw_reg[2];
  assign ref_buffer_en = buf_reg;
  assign divider_en = div_en_reg;
  assign pump_run = pump_reg;
  assign resistor_bias_run = res_reg;

  // ----------------------------------------
  // Register read-back
  // ----------------------------------------
  always_comb begin
    l.rd_data = 32'h0000_0000;
    l.rd_err = 1'b0;
    if (wave_rd_hit) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        if (l.rd_addr == 8'(WAVE_BASE_OFS + 4 * (i / 4))) begin
          l.rd_data[8 * (i % 4) +: 8] = wave_reg[i];
        end
      end
    end else begin
      case (l.rd_addr)
        FLASH_CTRL_OFS: l.rd_data[6:0] = flash_reg;
        DISP_CFG_OFS: l.rd_data[3:0] = disp_reg;
        SUPPLY_CFG_OFS: l.rd_data[5:0] = supply_reg;
        STATUS_OFS: begin
          l.rd_data[ST_BLINK_BIT] = l.blink_period;
          l.rd_data[ST_MODE_LSB +: 2] = shown;
          l.rd_data[ST_HOLD_BIT] = hold_reg != 5'h00;
          l.rd_data[ST_SW_LSB +: 3] = sw_reg;
          l.rd_data[ST_BUF_BIT] = buf_reg;
          l.rd_data[ST_PHASE_LSB +: 3] = phase_reg;
        end
        default: l.rd_err = 1'b1;
      endcase
    end
  end

  sldb_axil_slave u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .l(l.bus)
  );
endmodule : sldb_top

// >>> testbench/sldb_glass.sv
`timescale 1ns/1ps
module sldb_glass #(
  parameter int NUM_PINS = 16
) (
  input logic [NUM_PINS-1:0] seg_drive,
  input logic seg_drive_en,
  output logic [NUM_PINS-1:0] lit
);
  // Disabled drivers keep the glass dark
  assign lit = seg_drive_en ? seg_drive : '0;
endmodule : sldb_glass

// >>> testbench/sldb_assertions.sv
`timescale 1ns/1ps
module sldb_checker #(
  parameter int NUM_PINS = 16
) (
  input logic aclk,
  input logic aresetn,
  input logic [sldb_pkg::ADDR_W-1:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic [sldb_pkg::DATA_W-1:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic s_axi_bvalid,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic s_axi_rvalid,
  input logic [NUM_PINS-1:0] seg_drive,
  input logic seg_drive_en,
  input logic supply_switch_one,
  input logic supply_switch_two,
  input logic supply_switch_three,
  input logic ref_buffer_en,
  input logic divider_en,
  input logic pump_run,
  input logic resistor_bias_run
);
  import sldb_pkg::*;
  // ----------------------------------------
  // Written configuration
  // ----------------------------------------
  logic wr_hit, alt_ok, blank;
  logic [6:0] fl_sh, dc_sh, sc_sh;
  logic [2:0] age;
  logic [15:0] hold_cnt;
  assign wr_hit = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
  assign alt_ok = dc_sh[2:0] <= DUTY_ALT_MAX;
  // Blank in both periods, so blink phase is moot
  assign blank = (fl_sh[FL_CLR_BIT] && !(fl_sh[FL_EN_BIT] && fl_sh[FL_MODE_BIT] && alt_ok))
    || (!alt_ok && fl_sh[FL_ALT_BIT]);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fl_sh <= '0;
      dc_sh <= '0;
      sc_sh <= 7'(SUPPLY_SRC_RST);
      age <= '0;
      hold_cnt <= '0;
    end else begin
      age <= (age == 3'h4) ? age : age + 3'h1;
      if (hold_cnt != 16'h0 && hold_cnt != 16'hFFFF) hold_cnt <= hold_cnt + 16'h1;
      if (wr_hit) begin
        age <= '0;
        if (s_axi_awaddr == FLASH_CTRL_OFS) fl_sh <= s_axi_wdata[6:0];
        if (s_axi_awaddr == DISP_CFG_OFS) dc_sh <= s_axi_wdata[6:0];
        if (s_axi_awaddr == SUPPLY_CFG_OFS) begin
          sc_sh <= s_axi_wdata[6:0];
          if (s_axi_wdata[SC_PUMPEN_BIT] && !sc_sh[SC_PUMPEN_BIT]) hold_cnt <= 16'h1;
        end
      end
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_switch_decode: assert property (age == 3'h4 |->
    {supply_switch_one, supply_switch_two, supply_switch_three} ==
    {sc_sh[1:0] == SRC_SW1, sc_sh[1:0] == SRC_SW2, sc_sh[1:0] == SRC_SW3})
    else $error("supply switch decode wrong");
  a_buffer_enable: assert property (age == 3'h4 |->
    ref_buffer_en == (!sc_sh[SC_SKIP_BIT] && sc_sh[1:0] == SRC_SW3))
    else $error("buffer enable wrong");
  a_divider_select: assert property (age == 3'h4 |->
    divider_en == !sc_sh[SC_DIVREF_BIT])
    else $error("divider enable wrong");
  a_bias_source: assert property (age == 3'h4 |->
    pump_run == sc_sh[SC_PUMPSEL_BIT] && resistor_bias_run != pump_run)
    else $error("bias source wrong");
  a_blank_display: assert property (age == 3'h4 && blank |-> seg_drive == '0)
    else $error("segments lit when cleared");
  a_panel_gate: assert property (age == 3'h4 && !dc_sh[DC_PANEL_BIT] |-> !seg_drive_en)
    else $error("drive enabled with panel off");
  a_pump_hold: assert property (hold_cnt >= 16'h4 && hold_cnt <= 15 * BASE_DIV |->
    !seg_drive_en)
    else $error("drive on in pump hold");
  a_write_answer: assert property (wr_hit |-> ##[1:3] s_axi_bvalid)
    else $error("write response missing");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:4] s_axi_rvalid)
    else $error("read response missing");
endmodule : sldb_checker

// >>> testbench/sldb_bench.sv
`timescale 1ns/1ps
module sldb_bench;
  import sldb_pkg::*;
  localparam int BB = 4;
  localparam logic [6:0] FL [7] = '{7'h00, 7'h20, 7'h40, 7'h60, 7'h20, 7'h20, 7'h40};
  localparam logic [2:0] DU [7] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h3, 3'h4, 3'h7};
  localparam logic [3:0] EX [7] = '{4'h1, 4'h2, 4'h0, 4'h0, 4'h2, 4'h0, 4'h0};
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] seg_drive, lit;
  logic seg_drive_en, supply_switch_one, supply_switch_two, supply_switch_three;
  logic ref_buffer_en, divider_en, pump_run, resistor_bias_run;
  int bad_count = 0;
  int samples_checked = 0;
  sldb_top #(.NUM_PINS(16), .BLINK_BASE(BB)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .seg_drive, .seg_drive_en, .supply_switch_one,
    .supply_switch_two, .supply_switch_three, .ref_buffer_en, .divider_en, .pump_run,
    .resistor_bias_run);
  sldb_glass #(.NUM_PINS(16)) panel (.seg_drive, .seg_drive_en, .lit);
  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    check("awready", 32'h0, 32'(s_axi_awready));
    check("bresp", 32'(er), 32'(s_axi_bresp));
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    check("rresp", 32'(er), 32'(s_axi_rresp));
    if (er == RESP_OKAY) check("rdata", ed, s_axi_rdata);
  endtask : axi_read
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_supply;
    logic [2:0] sw;
    axi_read(SUPPLY_CFG_OFS, 32'h1, RESP_OKAY);
    for (int i = 0; i < 16; i++) begin
      axi_write(SUPPLY_CFG_OFS, {27'h0, i[0], i[3:0]}, RESP_OKAY);
      repeat (3) @(posedge aclk);
      sw = {supply_switch_one, supply_switch_two, supply_switch_three};
      check("switches", (i[1:0] == 2'h3) ? 32'h0 : 32'h4 >> i[1:0], 32'(sw));
      check("buffer", 32'(!i[3] && i[1:0] == 2'h2), 32'(ref_buffer_en));
      sw = {divider_en, pump_run, resistor_bias_run};
      check("bias", {29'h0, !i[2], i[0], !i[0]}, 32'(sw));
    end
    axi_write(8'hF0, 32'hFFFF_FFFF, RESP_SLVERR);
    axi_read(8'hF0, 32'h0, RESP_SLVERR);
  endtask : t_supply
  task automatic t_modes;
    // Pin 0 lit in phases A-D, pin 1 in E-H
    axi_write(WAVE_BASE_OFS, 32'h0000_F00F, RESP_OKAY);
    for (int k = 0; k < 7; k++) begin
      axi_write(DISP_CFG_OFS, {28'h0, 1'h1, DU[k]}, RESP_OKAY);
      axi_write(FLASH_CTRL_OFS, 32'(FL[k]), RESP_OKAY);
      repeat (4) @(posedge aclk);
      check("segments", 32'(EX[k]), 32'(lit[3:0]));
    end
  endtask : t_modes
  task automatic t_blink(input logic [2:0] rate, input logic mode, input logic [3:0] eb);
    int n;
    logic [3:0] v;
    axi_write(DISP_CFG_OFS, 32'h8, RESP_OKAY);
    axi_write(FLASH_CTRL_OFS, {27'h0, rate, mode, 1'h1}, RESP_OKAY);
    for (int p = 0; p < 3; p++) begin
      v = lit[3:0];
      n = 0;
      while (lit[3:0] === v) begin
        @(posedge aclk);
        n++;
      end
      if (p > 1) check("period", (BB << rate) * BASE_DIV, n);
      check("shown", (v == 4'h1) ? eb : 4'h1, 32'(lit[3:0]));
    end
  endtask : t_blink
  task automatic t_hold;
    int n;
    axi_write(FLASH_CTRL_OFS, 32'h0, RESP_OKAY);
    repeat (3) @(posedge aclk);
    check("drive enable", 32'h1, 32'(seg_drive_en));
    axi_write(SUPPLY_CFG_OFS, 32'h30, RESP_OKAY);
    repeat (2) @(posedge aclk);
    check("dark glass", 32'h0, 32'(lit));
    n = 0;
    while (seg_drive_en !== 1'h1) begin
      @(posedge aclk);
      n++;
    end
    check("hold", 32'h1, 32'(n >= 15 * BASE_DIV - 4 && n <= 16 * BASE_DIV + 4));
  endtask : t_hold
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    aclk = 1'h0;
    forever #20 aclk = ~aclk;
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    t_supply();
    t_modes();
    t_blink(3'h0, 1'h0, 4'h0);
    t_blink(3'h1, 1'h1, 4'h2);
    t_hold();
    tally_and_finish();
  end
  // Tests need about 40000 clocks
  initial begin
    #(80000 * 40);
    bad_count++;
    tally_and_finish();
  end
endmodule : sldb_bench
bind sldb_top sldb_checker #(.NUM_PINS(NUM_PINS)) chk (.aclk, .aresetn, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .seg_drive, .seg_drive_en,
  .supply_switch_one, .supply_switch_two, .supply_switch_three, .ref_buffer_en, .divider_en,
  .pump_run, .resistor_bias_run);
